// [logic/rdp_pkg.sv]
package rdp_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BYPASS_REFDIV = 8'h1b;
	localparam logic [7:0] ADDR_DEBUG_RSVD = 8'h1c;
	localparam logic [7:0] ADDR_FB_DIVIDE = 8'h1d;
	localparam logic [7:0] ADDR_PUMP_PRESCALE = 8'h1e;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_BYPASS_REFDIV = 16'h0000;
	localparam logic [15:0] RST_DEBUG_RSVD = 16'h0000;
	localparam logic [15:0] RST_FB_DIVIDE = 16'h000c;
	localparam logic [15:0] RST_PUMP_PRESCALE = 16'h5140;

	// ----------------------------------------------------------------
	// field positions, bypass/refdiv register
	// ----------------------------------------------------------------
	localparam int BYP_EN_HI = 14;
	localparam int BYP_EN_LO = 11;
	localparam int COPY_EN_BIT = 10;
	localparam int COPY_SEL_BIT = 9;
	localparam int DIV_RST_BIT = 8;
	localparam int RDIV_HI = 7;
	localparam int RDIV_LO = 0;

	// ----------------------------------------------------------------
	// field positions, pll registers
	// ----------------------------------------------------------------
	localparam int FB_PS_HI = 15;
	localparam int FB_PS_LO = 14;
	localparam int FB_NDIV_HI = 13;
	localparam int FB_NDIV_LO = 0;
	localparam int CP_UP_HI = 15;
	localparam int CP_UP_LO = 10;
	localparam int CP_DN_HI = 9;
	localparam int CP_DN_LO = 4;
	localparam int PS_B_HI = 3;
	localparam int PS_B_LO = 2;
	localparam int PS_A_HI = 1;
	localparam int PS_A_LO = 0;

	// ----------------------------------------------------------------
	// prescaler ratios, and the divider ratio that selects the doubler
	// ----------------------------------------------------------------
	localparam logic [2:0] PS_RATIO_4 = 3'h4;
	localparam logic [2:0] PS_RATIO_5 = 3'h5;
	localparam logic [2:0] PS_RATIO_6 = 3'h6;
	localparam logic [7:0] RDIV_DOUBLER = 8'h00;

endpackage : rdp_pkg

// [logic/rdp_ref_divider.sv]
`timescale 1ns/1ps
`default_nettype none

// reference divider: one-cycle tick every ratio cycles of clk, every cycle for ratio zero
module rdp_ref_divider #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic div_reset,
	input wire logic [WIDTH-1:0] ratio,
	// outputs
	output logic tick,
	output logic doubler_on
);

	logic [WIDTH-1:0] count_q, count_d;
	logic tick_q, tick_d;
	logic dbl_q, dbl_d;
	logic [WIDTH-1:0] period;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// ratio zero runs the counter at full rate; the doubler itself is analog
	always_comb begin
		period = (ratio == '0) ? WIDTH'(1) : ratio;
		dbl_d = (ratio == '0);
		if (div_reset) begin
			count_d = '0;
			tick_d = 1'b0;
		end else if (count_q + WIDTH'(1) >= period) begin
			count_d = '0;
			tick_d = 1'b1;
		end else begin
			count_d = count_q + WIDTH'(1);
			tick_d = 1'b0;
		end
	end

	// registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= '0;
			tick_q <= 1'b0;
			dbl_q <= 1'b0;
		end else begin
			count_q <= count_d;
			tick_q <= tick_d;
			dbl_q <= dbl_d;
		end
	end

	assign tick = tick_q;
	assign doubler_on = dbl_q;

endmodule : rdp_ref_divider

`default_nettype wire

// [logic/rdp_config.sv]
`timescale 1ns/1ps
`default_nettype none

module rdp_config (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// reset sources
	input wire logic software_reset,
	input wire logic pin_reset_n,
	// register port from the serial interface
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// input path controls
	output logic [3:0] bypass_buf_enable,
	output logic ref_copy_out_enable,
	output logic ref_copy_source_select,
	output logic ref_divider_reset,
	output logic [7:0] ref_divider_ratio,
	output logic frequency_doubler_enable,
	output logic phase_detector_clock,
	output logic ref_copy_output,
	// pll controls
	output logic [1:0] fb_prescale_code,
	output logic [2:0] fb_prescale_ratio,
	output logic [13:0] fb_divide_value,
	output logic [5:0] pump_up_current_code,
	output logic [5:0] pump_down_current_code,
	output logic [2:0] prescale_a_ratio,
	output logic [2:0] prescale_b_ratio
);

	// prescaler code to ratio; code 3 is undefined and falls back to four
	function automatic logic [2:0] rdp_ps_ratio(input logic [1:0] code);
		case (code)
			2'h1: rdp_ps_ratio = rdp_pkg::PS_RATIO_5;
			2'h2: rdp_ps_ratio = rdp_pkg::PS_RATIO_6;
			default: rdp_ps_ratio = rdp_pkg::PS_RATIO_4;
		endcase
	endfunction : rdp_ps_ratio

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [15:0] byp_q, byp_d;
	logic [15:0] dbg_q, dbg_d;
	logic [15:0] fbd_q, fbd_d;
	logic [15:0] cpp_q, cpp_d;
	logic [15:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic [2:0] fb_ratio_q, fb_ratio_d;
	logic [2:0] psa_ratio_q, psa_ratio_d;
	logic [2:0] psb_ratio_q, psb_ratio_d;
	logic pin_meta_q, pin_sync_q;
	logic div_rst_q, div_rst_d;
	logic copy_q, copy_d;
	logic ref_phase_q, ref_phase_d;
	logic pfd_tick;
	logic dbl_on;

	// writes land one cycle after the strobe; a read answers next cycle
	always_comb begin
		byp_d = byp_q;
		dbg_d = dbg_q;
		fbd_d = fbd_q;
		cpp_d = cpp_q;
		if (reg_write) begin
			if (reg_addr == rdp_pkg::ADDR_BYPASS_REFDIV) begin
				byp_d = reg_wdata;
			end else if (reg_addr == rdp_pkg::ADDR_DEBUG_RSVD) begin
				dbg_d = reg_wdata;
			end else if (reg_addr == rdp_pkg::ADDR_FB_DIVIDE) begin
				fbd_d = reg_wdata;
			end else if (reg_addr == rdp_pkg::ADDR_PUMP_PRESCALE) begin
				cpp_d = reg_wdata;
			end
		end
		rvalid_d = reg_read;
		rdata_d = 16'h0000; // unmapped offsets read zero
		if (reg_read) begin
			if (reg_addr == rdp_pkg::ADDR_BYPASS_REFDIV) begin
				// bit 8 shows the live divider reset, not just the stored bit
				rdata_d = byp_q;
				rdata_d[rdp_pkg::DIV_RST_BIT] = div_rst_q;
			end else if (reg_addr == rdp_pkg::ADDR_DEBUG_RSVD) begin
				rdata_d = dbg_q;
			end else if (reg_addr == rdp_pkg::ADDR_FB_DIVIDE) begin
				rdata_d = fbd_q;
			end else if (reg_addr == rdp_pkg::ADDR_PUMP_PRESCALE) begin
				rdata_d = cpp_q;
			end
		end
		// decoded ratios track the code registers in the same cycle
		fb_ratio_d = rdp_ps_ratio(fbd_d[rdp_pkg::FB_PS_HI:rdp_pkg::FB_PS_LO]);
		psa_ratio_d = rdp_ps_ratio(cpp_d[rdp_pkg::PS_A_HI:rdp_pkg::PS_A_LO]);
		psb_ratio_d = rdp_ps_ratio(cpp_d[rdp_pkg::PS_B_HI:rdp_pkg::PS_B_LO]);
	end

	// registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			byp_q <= rdp_pkg::RST_BYPASS_REFDIV;
			dbg_q <= rdp_pkg::RST_DEBUG_RSVD;
			fbd_q <= rdp_pkg::RST_FB_DIVIDE;
			cpp_q <= rdp_pkg::RST_PUMP_PRESCALE;
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			fb_ratio_q <= rdp_pkg::PS_RATIO_4;
			psa_ratio_q <= rdp_pkg::PS_RATIO_4;
			psb_ratio_q <= rdp_pkg::PS_RATIO_4;
		end else begin
			byp_q <= byp_d;
			dbg_q <= dbg_d;
			fbd_q <= fbd_d;
			cpp_q <= cpp_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			fb_ratio_q <= fb_ratio_d;
			psa_ratio_q <= psa_ratio_d;
			psb_ratio_q <= psb_ratio_d;
		end
	end

	// ----------------------------------------------------------------
	// divider reset and reference-copy output
	// ----------------------------------------------------------------
	// the pin is asynchronous, so it is synchronised before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= ~pin_reset_n;
			pin_sync_q <= pin_meta_q;
		end
	end

	// power-on reset keeps the divider reset high until the first edge after release
	always_comb begin
		div_rst_d = byp_q[rdp_pkg::DIV_RST_BIT] | software_reset | pin_sync_q;
		ref_phase_d = ~ref_phase_q;
		copy_d = 1'b0;
		if (byp_q[rdp_pkg::COPY_EN_BIT]) begin
			copy_d = byp_q[rdp_pkg::COPY_SEL_BIT] ? pfd_tick : ref_phase_q;
		end
	end

	// registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_rst_q <= 1'b1;
			copy_q <= 1'b0;
			ref_phase_q <= 1'b0;
		end else begin
			div_rst_q <= div_rst_d;
			copy_q <= copy_d;
			ref_phase_q <= ref_phase_d;
		end
	end

	// divider counts only while its reset is low
	rdp_ref_divider #(
		.WIDTH(8)
	) u_ref_div (
		.clk(clk),
		.reset_n(reset_n),
		.div_reset(div_rst_q),
		.ratio(byp_q[rdp_pkg::RDIV_HI:rdp_pkg::RDIV_LO]),
		.tick(pfd_tick),
		.doubler_on(dbl_on)
	);

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign bypass_buf_enable = byp_q[rdp_pkg::BYP_EN_HI:rdp_pkg::BYP_EN_LO];
	assign ref_copy_out_enable = byp_q[rdp_pkg::COPY_EN_BIT];
	assign ref_copy_source_select = byp_q[rdp_pkg::COPY_SEL_BIT];
	assign ref_divider_reset = div_rst_q;
	assign ref_divider_ratio = byp_q[rdp_pkg::RDIV_HI:rdp_pkg::RDIV_LO];
	assign frequency_doubler_enable = dbl_on;
	assign phase_detector_clock = pfd_tick;
	assign ref_copy_output = copy_q;
	assign fb_prescale_code = fbd_q[rdp_pkg::FB_PS_HI:rdp_pkg::FB_PS_LO];
	assign fb_prescale_ratio = fb_ratio_q;
	assign fb_divide_value = fbd_q[rdp_pkg::FB_NDIV_HI:rdp_pkg::FB_NDIV_LO];
	assign pump_up_current_code = cpp_q[rdp_pkg::CP_UP_HI:rdp_pkg::CP_UP_LO];
	assign pump_down_current_code = cpp_q[rdp_pkg::CP_DN_HI:rdp_pkg::CP_DN_LO];
	assign prescale_a_ratio = psa_ratio_q;
	assign prescale_b_ratio = psb_ratio_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_bypass_enable_write: assert property (reg_write && reg_addr == rdp_pkg::ADDR_BYPASS_REFDIV
		|=> bypass_buf_enable == $past(reg_wdata[14:11])) else $error("bypass enables not written");
	a_copy_off_low: assert property (!ref_copy_out_enable |=> !ref_copy_output)
		else $error("copy output active while disabled");
	a_copy_pfd_source: assert property (ref_copy_out_enable && ref_copy_source_select
		|=> ref_copy_output == $past(phase_detector_clock)) else $error("copy output not pfd clock");
	a_div_reset_static: assert property (ref_divider_reset |=> !phase_detector_clock)
		else $error("divider ticked while in reset");
	a_reset_sources: assert property (software_reset |=> ref_divider_reset)
		else $error("software reset did not reach divider");
	a_div_by_two: assert property ((phase_detector_clock && ref_divider_ratio == 8'h02 && !ref_divider_reset)
		##1 (!ref_divider_reset && ref_divider_ratio == 8'h02) |=> phase_detector_clock)
		else $error("divide by two period wrong");
	a_doubler_zero: assert property (ref_divider_ratio == 8'h00 |=> frequency_doubler_enable)
		else $error("doubler not on for ratio zero");
	a_fb_prescale_map: assert property (fb_prescale_code == 2'h1 |-> fb_prescale_ratio == 3'h5)
		else $error("feedback prescale code 1 not divide by five");
	// the host leaves one idle edge between accesses, so the read follows the write two edges later
	a_debug_readback: assert property ((reg_write && reg_addr == rdp_pkg::ADDR_DEBUG_RSVD)
		##1 !(reg_write && reg_addr == rdp_pkg::ADDR_DEBUG_RSVD)
		##1 (reg_read && !reg_write && reg_addr == rdp_pkg::ADDR_DEBUG_RSVD)
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("debug register readback wrong");
	a_fb_reset_value: assert property ($rose(reset_n) |-> fb_divide_value == 14'h000c && fb_prescale_ratio == 3'h4)
		else $error("feedback register reset value wrong");
	a_pump_reset_value: assert property ($rose(reset_n) |-> pump_up_current_code == 6'h14
		&& pump_down_current_code == 6'h14 && prescale_a_ratio == 3'h4 && prescale_b_ratio == 3'h4)
		else $error("pump register reset value wrong");
	// counter restarts at zero, so the first tick is seen three edges after the fall is sampled
	a_div_restart: assert property ($fell(ref_divider_reset) && ref_divider_ratio == 8'h03
		##1 (!ref_divider_reset && ref_divider_ratio == 8'h03) [*2]
		|-> !phase_detector_clock && !$past(phase_detector_clock) && !$past(phase_detector_clock, 2)
		##1 phase_detector_clock) else $error("divider did not restart from zero");

	c_doubler: cover property (frequency_doubler_enable && phase_detector_clock);
	c_copy_pfd: cover property (ref_copy_out_enable && ref_copy_source_select && ref_copy_output);
	c_sw_reset: cover property (software_reset ##1 ref_divider_reset ##1 !ref_divider_reset);
	c_debug_read: cover property (reg_read && reg_addr == rdp_pkg::ADDR_DEBUG_RSVD ##1 reg_rvalid);

endmodule : rdp_config

`default_nettype wire

// [test/rdp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// host side of the register port: one strobe per access, launched on the falling edge
module rdp_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle bus before the first access
	initial begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'hff;
		reg_wdata = 16'h0000;
	end

	// one-cycle write strobe; the released bus shows inverted values so stale data never passes
	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		@(negedge clk);
		reg_addr = addr;
		reg_wdata = data;
		reg_write = 1'b1;
		@(negedge clk);
		reg_write = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask : wr

	// one-cycle read strobe, then a bounded wait for the answer
	task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic ok);
		ok = 1'b0;
		data = 16'h0000;
		@(negedge clk);
		reg_addr = addr;
		reg_read = 1'b1;
		@(negedge clk);
		reg_read = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				data = reg_rdata;
			end else begin
				@(negedge clk);
			end
		end
		reg_addr = ~addr;
	endtask : rd
endmodule : rdp_host_model

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk, reset_n, software_reset, pin_reset_n;
	logic reg_write, reg_read, reg_rvalid;
	logic [7:0] reg_addr, ref_divider_ratio;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [3:0] bypass_buf_enable;
	logic ref_copy_out_enable, ref_copy_source_select, ref_divider_reset, frequency_doubler_enable;
	logic phase_detector_clock, ref_copy_output, ok;
	logic [1:0] fb_prescale_code;
	logic [2:0] fb_prescale_ratio, prescale_a_ratio, prescale_b_ratio;
	logic [13:0] fb_divide_value;
	logic [5:0] pump_up_current_code, pump_down_current_code;
	int err_total = 0;
	int n_compared = 0;
	int p, c;

	rdp_config u_dut (.clk(clk), .reset_n(reset_n), .software_reset(software_reset),
		.pin_reset_n(pin_reset_n), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.bypass_buf_enable(bypass_buf_enable), .ref_copy_out_enable(ref_copy_out_enable),
		.ref_copy_source_select(ref_copy_source_select), .ref_divider_reset(ref_divider_reset),
		.ref_divider_ratio(ref_divider_ratio), .frequency_doubler_enable(frequency_doubler_enable),
		.phase_detector_clock(phase_detector_clock), .ref_copy_output(ref_copy_output),
		.fb_prescale_code(fb_prescale_code), .fb_prescale_ratio(fb_prescale_ratio),
		.fb_divide_value(fb_divide_value), .pump_up_current_code(pump_up_current_code),
		.pump_down_current_code(pump_down_current_code), .prescale_a_ratio(prescale_a_ratio),
		.prescale_b_ratio(prescale_b_ratio));

	rdp_host_model u_host (.clk(clk), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// ----------------------------------------------------------------
	// clock, watchdog and shared tasks
	// ----------------------------------------------------------------
	// 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// a hang counts as a mismatch and ends the run
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		test_done();
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// register read with a timeout that also counts as a mismatch
	task automatic rchk(input logic [7:0] addr, input logic [15:0] exp);
		u_host.rd(addr, d, ok);
		chk({15'h0, ok}, 16'h0001);
		chk(d, exp);
	endtask : rchk

	// counts one-cycle pulses; windows are whole periods except after the ratio-3 restart, where the phase is known
	task automatic cnt(input int n);
		p = 0;
		c = 0;
		repeat (n) begin
			@(negedge clk);
			if (phase_detector_clock === 1'b1) p++;
			if (ref_copy_output === 1'b1) c++;
		end
	endtask : cnt

	task automatic test_done();
		$display("mismatches %0d of %0d compares", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		software_reset = 1'b0;
		pin_reset_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(16'(ref_divider_reset), 16'h0001);
		reset_n = 1'b1;
		rchk(8'h1b, 16'h0000);
		rchk(8'h1c, 16'h0000);
		rchk(8'h1d, 16'h000c);
		rchk(8'h1e, 16'h5140);
		rchk(8'h1f, 16'h0000);
		chk({4'h0, pump_up_current_code, pump_down_current_code}, 16'h0514);
		chk({13'h0, fb_prescale_ratio}, 16'h0004);
		chk({2'h0, fb_divide_value}, 16'h000c);
		chk({10'h0, prescale_b_ratio, prescale_a_ratio}, 16'h0024);
		u_host.wr(8'h1c, 16'ha5c3);
		rchk(8'h1c, 16'ha5c3);
		// prescaler codes 0 to 2; feedback divider kept at six or more
		for (int k = 0; k < 3; k++) begin
			u_host.wr(8'h1d, {2'(k), 14'(6 + k)});
			u_host.wr(8'h1e, {6'(20 + k), 6'(k), 2'(k), 2'(2 - k)});
			@(negedge clk);
			chk(16'(fb_prescale_ratio), 16'(4 + k));
			chk(16'(fb_prescale_code), 16'(k));
			chk(16'(fb_divide_value), 16'(6 + k));
			chk({4'h0, pump_up_current_code, pump_down_current_code}, {4'h0, 6'(20 + k), 6'(k)});
			chk({10'h0, prescale_b_ratio, prescale_a_ratio}, {10'h0, 3'(4 + k), 3'(6 - k)});
		end
		// buffer enable goes first, before any bypass selection at a channel mux
		for (int k = 0; k < 4; k++) begin
			u_host.wr(8'h1b, 16'h0800 << k);
			chk(16'(bypass_buf_enable), 16'h0001 << k);
		end
		u_host.wr(8'h1b, 16'h0602);
		chk(16'(ref_copy_out_enable), 16'h0001);
		chk(16'(ref_copy_source_select), 16'h0001);
		chk(16'(ref_divider_ratio), 16'h0002);
		repeat (10) @(negedge clk);
		cnt(40);
		chk(16'(p), 16'h0014);
		chk(16'(c), 16'h0014);
		u_host.wr(8'h1b, 16'h0005);
		cnt(40);
		chk(16'(c), 16'h0000);
		// reference source: the copy shows the clk/2 stand-in, one high cycle in two
		u_host.wr(8'h1b, 16'h0400);
		cnt(40);
		chk(16'(c), 16'h0014);
		u_host.wr(8'h1b, 16'h0000);
		@(negedge clk);
		chk(16'(frequency_doubler_enable), 16'h0001);
		u_host.wr(8'h1b, 16'h00ff);
		repeat (300) @(negedge clk);
		cnt(1020);
		chk(16'(p), 16'h0004);
		// divider held by its control bit: no pulses, then counting resumes
		// the divider reset follows the stored bit one edge late
		u_host.wr(8'h1b, 16'h0103);
		@(negedge clk);
		chk(16'(ref_divider_reset), 16'h0001);
		rchk(8'h1b, 16'h0103);
		cnt(20);
		chk(16'(p), 16'h0000);
		// restart from zero: first tick four edges after release, then every third cycle
		u_host.wr(8'h1b, 16'h0003);
		cnt(40);
		chk(16'(p), 16'h000d);
		software_reset = 1'b1;
		@(negedge clk);
		chk(16'(ref_divider_reset), 16'h0001);
		software_reset = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'(ref_divider_reset), 16'h0000);
		pin_reset_n = 1'b0;
		repeat (4) @(negedge clk);
		chk(16'(ref_divider_reset), 16'h0001);
		rchk(8'h1b, 16'h0103);
		pin_reset_n = 1'b1;
		repeat (5) @(negedge clk);
		chk(16'(ref_divider_reset), 16'h0000);
		reset_n = 1'b0;
		@(negedge clk);
		chk(16'(ref_divider_reset), 16'h0001);
		reset_n = 1'b1;
		rchk(8'h1d, 16'h000c);
		test_done();
	end
endmodule : testbench

`default_nettype wire
